/* inc/sdcs_pkg.sv */
// constants, types and helper functions for the serial drive control slave
// assumes a 10 MHz system clock and a half-duplex two-wire transceiver outside
//
// Behaviour
// R01: each character is one start bit, eight data bits, one stop bit, no parity.
// R02: bit rate selectable 9600 to 115200; 115200 when nothing else is chosen.
// R03: frames end in a Modbus CRC-16; frames with a bad check are silently dropped.
// R04: function 03 returns a contiguous run of holding registers from the start register.
// R05: function 06 writes one holding register with the supplied 16-bit value.
// R06: function 16 accepted only when every addressed register lies in 1 through 4.
// R07: command bit 0 low requests stop, high enables running.
// R08: command bit 1 selects deceleration ramp one when low, ramp two when high.
// R09: command bit 2 set requests a fault reset; cleared does nothing.
// R10: command bit 3 set requests a coast stop without ramp; cleared does nothing.
// R11: speed setpoint is output frequency in tenths of a hertz.
// R12: ramp time is acceleration and deceleration time in hundredths of a second.
// R13: read-only status word: error code low byte, drive state high byte (0/1/2).
package sdcs_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned BAUD_9600 = 9600;
	localparam int unsigned BAUD_19200 = 19200;
	localparam int unsigned BAUD_38400 = 38400;
	localparam int unsigned BAUD_57600 = 57600;
	localparam int unsigned BAUD_115200 = 115200;
	localparam logic [10:0] DIV_9600 = 11'(CLK_HZ / BAUD_9600);
	localparam logic [10:0] DIV_19200 = 11'(CLK_HZ / BAUD_19200);
	localparam logic [10:0] DIV_38400 = 11'(CLK_HZ / BAUD_38400);
	localparam logic [10:0] DIV_57600 = 11'(CLK_HZ / BAUD_57600);
	localparam logic [10:0] DIV_115200 = 11'(CLK_HZ / BAUD_115200);
	localparam logic [2:0] SEL_9600 = 3'h0;
	localparam logic [2:0] SEL_19200 = 3'h1;
	localparam logic [2:0] SEL_38400 = 3'h2;
	localparam logic [2:0] SEL_57600 = 3'h3;
	localparam logic [3:0] START_POS = 4'h0;
	localparam logic [3:0] STOP_POS = 4'h9;
	// 3.5 characters of ten bits each
	localparam logic [5:0] GAP_BITS = 6'h23;
	localparam logic [7:0] FN_READ = 8'h03;
	localparam logic [7:0] FN_WRITE1 = 8'h06;
	localparam logic [7:0] FN_WRITEN = 8'h10;
	localparam logic [7:0] FN_EXC = 8'h80;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [15:0] REG_CMD = 16'h0001;
	localparam logic [15:0] REG_SPEED = 16'h0002;
	localparam logic [15:0] REG_RAMP = 16'h0004;
	localparam logic [15:0] REG_STATUS = 16'h0006;
	localparam logic [15:0] REG_MULTI_LAST = 16'h0004;
	localparam logic [15:0] REG_READ_LAST = 16'h0006;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam int CMD_RUN = 0;
	localparam int CMD_DECEL2 = 1;
	localparam int CMD_FRESET = 2;
	localparam int CMD_COAST = 3;
	localparam int MAX_WORDS = 4;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam int BUF_DEPTH = 24;
	localparam int B_ADDR = 0;
	localparam int B_FN = 1;
	localparam int B_AHI = 2;
	localparam int B_ALO = 3;
	localparam int B_CHI = 4;
	localparam int B_CLO = 5;
	localparam int B_BYTES = 6;
	localparam int B_DATA = 7;
	localparam logic [4:0] LEN_MIN = 5'h04;
	localparam logic [4:0] LEN_FIXED = 5'h08;
	localparam logic [15:0] LEN_MULTI = 16'h0009;
	localparam logic [5:0] RSP_HDR = 6'h03;
	localparam logic [5:0] ECHO_LEN = 6'h06;
	localparam logic [5:0] EXC_LEN = 6'h03;
	localparam logic [5:0] CRC_BYTES = 6'h02;

	typedef enum logic [1:0] {S_RX = 2'b01, S_TX = 2'b10} sdcs_state_t;

	function automatic logic [10:0] baud_div(input logic [2:0] sel);
		case (sel)
			SEL_9600: return DIV_9600;
			SEL_19200: return DIV_19200;
			SEL_38400: return DIV_38400;
			SEL_57600: return DIV_57600;
			default: return DIV_115200;
		endcase
	endfunction : baud_div

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		return r;
	endfunction : crc_step
endpackage : sdcs_pkg

/* rtl/sdcs_slave.sv */
// modbus rtu slave holding the drive command, speed and ramp registers
// assumes rx_pin comes from an rs485 receiver, tx_oe_n drives its transmitter enable
`timescale 1ns/1ps
module sdcs_slave (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	// serial line
	input wire logic rx_pin,
	output logic tx_out,
	output logic tx_oe_n,
	// configuration and drive status
	input wire logic [2:0] baud_sel,
	input wire logic [7:0] slave_addr,
	input wire logic [7:0] drive_err,
	input wire logic [1:0] drive_state,
	// drive controls
	output logic run_enable,
	output logic decel_ramp2,
	output logic fault_reset,
	output logic coast_stop,
	output logic [15:0] speed_setpoint,
	output logic [15:0] ramp_time
);
	////////////////////////////////////////////////////////////////////////////
	sdcs_pkg::sdcs_state_t state_q, state_d;
	logic rx_s1_q, rx_s2_q;
	logic [10:0] cnt_q, cnt_d;
	logic [3:0] bit_q, bit_d;
	logic busy_q, busy_d;
	logic [7:0] sh_q, sh_d;
	logic [8:0] txsh_q, txsh_d;
	logic [5:0] gap_q, gap_d;
	logic [4:0] len_q, len_d;
	logic ovf_q, ovf_d;
	logic [15:0] crc_q, crc_d, txcrc_q, txcrc_d;
	logic [7:0] buf_q [sdcs_pkg::BUF_DEPTH];
	logic [7:0] buf_d [sdcs_pkg::BUF_DEPTH];
	logic tx_q, tx_d, oe_n_q, oe_n_d;
	logic [5:0] idx_q, idx_d, txlen_q, txlen_d;
	logic [7:0] exc_q, exc_d;
	logic [15:0] cmd_q, cmd_d, speed_q, speed_d, ramp_q, ramp_d;
	logic [10:0] div;
	logic [15:0] st, cn;
	logic [7:0] fn;
	logic fr_end, fr_ok;

	assign div = sdcs_pkg::baud_div(baud_sel); // [R02]
	assign fn = buf_q[sdcs_pkg::B_FN];
	assign st = {buf_q[sdcs_pkg::B_AHI], buf_q[sdcs_pkg::B_ALO]};
	assign cn = {buf_q[sdcs_pkg::B_CHI], buf_q[sdcs_pkg::B_CLO]};
	// a frame closes after 3.5 quiet characters
	assign fr_end = state_q == sdcs_pkg::S_RX && !busy_q && gap_q == sdcs_pkg::GAP_BITS && len_q != 5'h00;
	// residue of zero over data plus check bytes means intact
	assign fr_ok = crc_q == 16'h0000 && !ovf_q && len_q >= sdcs_pkg::LEN_MIN
		&& buf_q[sdcs_pkg::B_ADDR] == slave_addr; // [R03]

	////////////////////////////////////////////////////////////////////////////
	function automatic logic rng_ok(input logic [15:0] s, input logic [15:0] n, input logic [15:0] last);
		return n != 16'h0000 && s != 16'h0000 && (17'(s) + 17'(n)) <= (17'(last) + 17'h00001);
	endfunction : rng_ok

	function automatic logic [15:0] reg_read(input logic [15:0] a);
		if (a == sdcs_pkg::REG_CMD)
			return cmd_q;
		else if (a == sdcs_pkg::REG_SPEED)
			return speed_q;
		else if (a == sdcs_pkg::REG_RAMP)
			return ramp_q;
		else if (a == sdcs_pkg::REG_STATUS)
			return {6'h00, drive_state, drive_err}; // [R13]
		else
			return 16'h0000;
	endfunction : reg_read

	function automatic logic [7:0] resp_byte(input logic [5:0] i);
		logic [5:0] j;
		logic [15:0] w;
		j = i - sdcs_pkg::RSP_HDR;
		w = reg_read(st + 16'(j[5:1])); // [R04]
		if (i == 6'h00)
			return buf_q[sdcs_pkg::B_ADDR];
		else if (exc_q != 8'h00)
			return (i == 6'h01) ? (fn | sdcs_pkg::FN_EXC) : exc_q;
		else if (fn != sdcs_pkg::FN_READ)
			return buf_q[i[4:0]];
		else if (i == 6'h01)
			return fn;
		else if (i == 6'h02)
			return {cn[6:0], 1'b0};
		else
			return j[0] ? w[7:0] : w[15:8];
	endfunction : resp_byte

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic [3:0] nw;
		logic [4:0] db;
		logic [7:0] b;
		logic [15:0] a, v;
		logic go, tick;
		nw = 4'h0;
		db = 5'h00;
		b = 8'h00;
		a = 16'h0000;
		v = 16'h0000;
		go = 1'b1;
		tick = cnt_q == 11'h000;
		state_d = state_q;
		cnt_d = tick ? div - 11'h001 : cnt_q - 11'h001;
		bit_d = bit_q;
		busy_d = busy_q;
		sh_d = sh_q;
		txsh_d = txsh_q;
		gap_d = gap_q;
		len_d = len_q;
		ovf_d = ovf_q;
		crc_d = crc_q;
		buf_d = buf_q;
		tx_d = tx_q;
		oe_n_d = oe_n_q;
		idx_d = idx_q;
		txlen_d = txlen_q;
		txcrc_d = txcrc_q;
		exc_d = exc_q;
		cmd_d = cmd_q;
		speed_d = speed_q;
		ramp_d = ramp_q;
		case (state_q)
			sdcs_pkg::S_RX:
			begin
				if (!busy_q && !rx_s2_q)
				begin
					// sample mid-bit from here on
					busy_d = 1'b1;
					bit_d = sdcs_pkg::START_POS;
					gap_d = 6'h00;
					cnt_d = {1'b0, div[10:1]};
				end
				else if (fr_end)
				begin
					len_d = 5'h00;
					ovf_d = 1'b0;
					crc_d = sdcs_pkg::CRC_INIT;
					exc_d = 8'h00;
					if (fn == sdcs_pkg::FN_READ)
					begin
						go = len_q == sdcs_pkg::LEN_FIXED;
						txlen_d = sdcs_pkg::RSP_HDR + {cn[4:0], 1'b0};
						if (!rng_ok(st, cn, sdcs_pkg::REG_READ_LAST))
							exc_d = sdcs_pkg::EXC_ADDR; // [R04]
					end
					else if (fn == sdcs_pkg::FN_WRITE1)
					begin
						go = len_q == sdcs_pkg::LEN_FIXED;
						txlen_d = sdcs_pkg::ECHO_LEN;
						db = 5'(sdcs_pkg::B_CHI);
						nw = 4'h1;
						if (st != sdcs_pkg::REG_CMD && st != sdcs_pkg::REG_SPEED && st != sdcs_pkg::REG_RAMP)
							exc_d = sdcs_pkg::EXC_ADDR; // [R05]
					end
					else if (fn == sdcs_pkg::FN_WRITEN)
					begin
						go = {11'h000, len_q} == sdcs_pkg::LEN_MULTI + {cn[14:0], 1'b0}
							&& buf_q[sdcs_pkg::B_BYTES] == {cn[6:0], 1'b0};
						txlen_d = sdcs_pkg::ECHO_LEN;
						db = 5'(sdcs_pkg::B_DATA);
						nw = cn[3:0];
						if (!rng_ok(st, cn, sdcs_pkg::REG_MULTI_LAST))
							exc_d = sdcs_pkg::EXC_ADDR; // [R06]
					end
					else
						exc_d = sdcs_pkg::EXC_FUNC;
					if (exc_d != 8'h00)
					begin
						txlen_d = sdcs_pkg::EXC_LEN;
						nw = 4'h0;
					end
					if (fr_ok && go)
					begin
						state_d = sdcs_pkg::S_TX;
						oe_n_d = 1'b0;
						idx_d = 6'h00;
						txcrc_d = sdcs_pkg::CRC_INIT;
						for (int k = 0; k < sdcs_pkg::MAX_WORDS; k++)
						begin
							a = st + 16'(k);
							v = {buf_q[int'(db) + 2 * k], buf_q[int'(db) + 2 * k + 1]};
							if (4'(k) < nw && a == sdcs_pkg::REG_CMD)
								cmd_d = v; // [R05] [R06]
							else if (4'(k) < nw && a == sdcs_pkg::REG_SPEED)
								speed_d = v;
							else if (4'(k) < nw && a == sdcs_pkg::REG_RAMP)
								ramp_d = v;
						end
					end
				end
				else if (!busy_q && tick && gap_q != sdcs_pkg::GAP_BITS)
					gap_d = gap_q + 6'h01;
				else if (busy_q && tick)
				begin
					bit_d = bit_q + 4'h1;
					if (bit_q == sdcs_pkg::START_POS && rx_s2_q)
						busy_d = 1'b0; // glitch, not a start bit
					else if (bit_q == sdcs_pkg::STOP_POS)
					begin
						busy_d = 1'b0;
						// a missing stop bit drops the character [R01]
						if (rx_s2_q && len_q < 5'(sdcs_pkg::BUF_DEPTH))
						begin
							buf_d[len_q] = sh_q;
							len_d = len_q + 5'h01;
							crc_d = sdcs_pkg::crc_step(crc_q, sh_q); // [R03]
						end
						else if (rx_s2_q)
							ovf_d = 1'b1;
					end
					else if (bit_q != sdcs_pkg::START_POS)
						sh_d = {rx_s2_q, sh_q[7:1]}; // [R01]
				end
			end
			default:
			begin
				if (busy_q)
				begin
					if (tick && bit_q == sdcs_pkg::STOP_POS)
						busy_d = 1'b0;
					else if (tick)
					begin
						tx_d = txsh_q[0];
						txsh_d = {1'b1, txsh_q[8:1]};
						bit_d = bit_q + 4'h1;
					end
				end
				else if (idx_q == txlen_q + sdcs_pkg::CRC_BYTES)
				begin
					state_d = sdcs_pkg::S_RX;
					oe_n_d = 1'b1;
					gap_d = 6'h00;
				end
				else
				begin
					if (idx_q < txlen_q)
					begin
						b = resp_byte(idx_q);
						txcrc_d = sdcs_pkg::crc_step(txcrc_q, b); // [R03]
					end
					else
						b = (idx_q == txlen_q) ? txcrc_q[7:0] : txcrc_q[15:8];
					// start bit now, then data lsb first and a stop bit [R01]
					tx_d = 1'b0;
					txsh_d = {1'b1, b};
					busy_d = 1'b1;
					bit_d = sdcs_pkg::START_POS;
					cnt_d = div - 11'h001;
					idx_d = idx_q + 6'h01;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			state_q <= sdcs_pkg::S_RX;
			cnt_q <= 11'h000;
			bit_q <= 4'h0;
			busy_q <= 1'b0;
			sh_q <= 8'h00;
			txsh_q <= 9'h1ff;
			gap_q <= 6'h00;
			len_q <= 5'h00;
			ovf_q <= 1'b0;
			crc_q <= sdcs_pkg::CRC_INIT;
			buf_q <= '{default: 8'h00};
			tx_q <= 1'b1;
			oe_n_q <= 1'b1;
			idx_q <= 6'h00;
			txlen_q <= 6'h00;
			txcrc_q <= sdcs_pkg::CRC_INIT;
			exc_q <= 8'h00;
			cmd_q <= sdcs_pkg::CMD_RESET;
			speed_q <= sdcs_pkg::CMD_RESET;
			ramp_q <= sdcs_pkg::CMD_RESET;
		end
		else if (clk_en)
		begin
			rx_s1_q <= rx_pin;
			rx_s2_q <= rx_s1_q;
			state_q <= state_d;
			cnt_q <= cnt_d;
			bit_q <= bit_d;
			busy_q <= busy_d;
			sh_q <= sh_d;
			txsh_q <= txsh_d;
			gap_q <= gap_d;
			len_q <= len_d;
			ovf_q <= ovf_d;
			crc_q <= crc_d;
			buf_q <= buf_d;
			tx_q <= tx_d;
			oe_n_q <= oe_n_d;
			idx_q <= idx_d;
			txlen_q <= txlen_d;
			txcrc_q <= txcrc_d;
			exc_q <= exc_d;
			cmd_q <= cmd_d;
			speed_q <= speed_d;
			ramp_q <= ramp_d;
		end
	end

	assign tx_out = tx_q;
	assign tx_oe_n = oe_n_q;
	assign run_enable = cmd_q[sdcs_pkg::CMD_RUN]; // [R07]
	assign decel_ramp2 = cmd_q[sdcs_pkg::CMD_DECEL2]; // [R08]
	assign fault_reset = cmd_q[sdcs_pkg::CMD_FRESET]; // [R09]
	assign coast_stop = cmd_q[sdcs_pkg::CMD_COAST]; // [R10]
	// units pass through untouched: 0.1 Hz and 0.01 s
	assign speed_setpoint = speed_q; // [R11]
	assign ramp_time = ramp_q; // [R12]

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset || !clk_en);

	idle_line_a: assert property (state_q == sdcs_pkg::S_RX |-> tx_q && oe_n_q) else $error("line not idle"); // [R01]
	default_rate_a: assert property (baud_sel >= 3'h4 // [R02]
		|-> div == sdcs_pkg::DIV_115200) else $error("bad default rate");
	crc_drop_a: assert property (fr_end && crc_q != 16'h0000 // [R03]
		|=> state_q == sdcs_pkg::S_RX && $stable(cmd_q) && $stable(speed_q) && $stable(ramp_q))
		else $error("bad crc frame taken");
	read_len_a: assert property (fr_end && fr_ok && fn == sdcs_pkg::FN_READ && len_q == sdcs_pkg::LEN_FIXED // [R04]
		&& rng_ok(st, cn, sdcs_pkg::REG_READ_LAST) |=> state_q == sdcs_pkg::S_TX && txlen_q == 6'(3 + 2 * cn))
		else $error("read reply length wrong");
	write_one_a: assert property (fr_end && fr_ok && fn == sdcs_pkg::FN_WRITE1 // [R05]
		&& len_q == sdcs_pkg::LEN_FIXED
		&& (st == sdcs_pkg::REG_CMD || st == sdcs_pkg::REG_SPEED || st == sdcs_pkg::REG_RAMP)
		|=> (st == sdcs_pkg::REG_CMD ? cmd_q : (st == sdcs_pkg::REG_SPEED ? speed_q : ramp_q)) == $past(cn))
		else $error("single write lost");
	multi_range_a: assert property (fr_end && fn == sdcs_pkg::FN_WRITEN // [R06]
		&& !rng_ok(st, cn, sdcs_pkg::REG_MULTI_LAST) |=> $stable(cmd_q) && $stable(speed_q) && $stable(ramp_q))
		else $error("multi write out of range");
	cmd_run_a: assert property (fr_end && fr_ok && fn == sdcs_pkg::FN_WRITE1 // [R07] [R10]
		&& len_q == sdcs_pkg::LEN_FIXED
		&& st == sdcs_pkg::REG_CMD |=> run_enable == $past(cn[0]) && coast_stop == $past(cn[3]))
		else $error("run or coast bit wrong");
	cmd_ramp_a: assert property (fr_end && fr_ok && fn == sdcs_pkg::FN_WRITE1 // [R08] [R09]
		&& len_q == sdcs_pkg::LEN_FIXED
		&& st == sdcs_pkg::REG_CMD |=> decel_ramp2 == $past(cn[1]) && fault_reset == $past(cn[2]))
		else $error("ramp or reset bit wrong");
endmodule : sdcs_slave

/* tb/sdcs_master.sv */
// modbus rtu master model facing the drive control slave
// assumes the slave runs at its default rate, a bit being BIT_CLKS system clocks
`timescale 1ns/1ps
module sdcs_master #(
	parameter int BIT_CLKS = 86
) (
	// clock
	input wire logic clk_sys,
	// serial line
	output logic rx_line,
	input wire logic tx_out,
	input wire logic tx_oe_n
);
	logic [7:0] rx_q[$];

	// biased bus idles high between characters
	initial rx_line = 1'b1;

	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction : crc16

	////////////////////////////////////////////////////////////////
	// flip is xored into the check value so a bad frame can be sent
	task automatic send(input logic [7:0] q[$], input logic [15:0] flip);
		logic [15:0] c;
		logic [9:0] ch;
		c = crc16(q) ^ flip;
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i])
		begin
			ch = {1'b1, q[i], 1'b0};
			for (int b = 0; b < 10; b++)
			begin
				@(posedge clk_sys);
				#1 rx_line = ch[b];
				repeat (BIT_CLKS - 1) @(posedge clk_sys);
			end
		end
	endtask : send

	////////////////////////////////////////////////////////////////
	// characters with a low stop bit are dropped, so the count shows it
	always
	begin : rx_proc
		logic [7:0] d;
		@(negedge tx_out iff tx_oe_n === 1'b0);
		repeat (BIT_CLKS / 2) @(posedge clk_sys);
		for (int b = 0; b < 8; b++)
		begin
			repeat (BIT_CLKS) @(posedge clk_sys);
			d[b] = tx_out;
		end
		repeat (BIT_CLKS) @(posedge clk_sys);
		if (tx_out === 1'b1)
			rx_q.push_back(d);
	end
endmodule : sdcs_master

/* tb/sdcs_slave_tb.sv */
// self-checking bench for the drive control slave
// assumes the default rate of 115200, a divider of 86 clocks at 10 MHz
`timescale 1ns/1ps
module sdcs_slave_tb;
	localparam logic [7:0] ADDR = 8'h11;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic rx_pin;
	logic tx_out, tx_oe_n, run_enable, decel_ramp2, fault_reset, coast_stop;
	logic [1:0] drive_state = 2'h0;
	logic [7:0] drive_err = 8'h00;
	logic [15:0] speed_setpoint, ramp_time;
	int n_errors = 0;
	int n_tests = 0;

	always #50 clk_sys = ~clk_sys;

	sdcs_slave u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .rx_pin(rx_pin), .tx_out(tx_out),
		.tx_oe_n(tx_oe_n), .baud_sel(3'h4), .slave_addr(ADDR), .drive_err(drive_err), .drive_state(drive_state),
		.run_enable(run_enable), .decel_ramp2(decel_ramp2), .fault_reset(fault_reset), .coast_stop(coast_stop),
		.speed_setpoint(speed_setpoint), .ramp_time(ramp_time));

	sdcs_master u_mst (.clk_sys(clk_sys), .rx_line(rx_pin), .tx_out(tx_out), .tx_oe_n(tx_oe_n));

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		n_tests++;
		if (seen !== exp)
		begin
			$display("unexpected at %0t: %s seen %h wanted %h", $time, msg, seen, exp);
			n_errors++;
		end
	endtask : check

	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	// bounded wait for a whole reply, then the idle gap before the next request
	task automatic await_reply();
		int n;
		n = 0;
		while (tx_oe_n !== 1'b0 && n < 30000)
		begin
			@(posedge clk_sys);
			n++;
		end
		check({15'h0000, tx_oe_n}, 16'h0000, "no reply");
		n = 0;
		while (tx_oe_n !== 1'b1 && n < 30000)
		begin
			@(posedge clk_sys);
			n++;
		end
		check({15'h0000, tx_oe_n}, 16'h0001, "reply never ends");
		repeat (36 * 86) @(posedge clk_sys);
	endtask : await_reply

	task automatic check_reply(input logic [7:0] exp[$]);
		check(16'(u_mst.rx_q.size()), 16'(exp.size() + 2), "reply length");
		foreach (exp[i])
			if (i < u_mst.rx_q.size())
				check({8'h00, u_mst.rx_q[i]}, {8'h00, exp[i]}, "reply byte");
		check(u_mst.crc16(u_mst.rx_q), 16'h0000, "reply check value");
		u_mst.rx_q.delete();
	endtask : check_reply

	////////////////////////////////////////////////////////////////
	task automatic t_write_multi();
		u_mst.send({ADDR, 8'h10, 8'h00, 8'h01, 8'h00, 8'h04, 8'h08, 8'h00, 8'h0f, 8'h00, 8'h64,
			8'h12, 8'h34, 8'h00, 8'hfa}, 16'h0000);
		await_reply();
		check_reply({ADDR, 8'h10, 8'h00, 8'h01, 8'h00, 8'h04});
		check({12'h000, coast_stop, fault_reset, decel_ramp2, run_enable}, 16'h000f, "command");
		check(speed_setpoint, 16'h0064, "speed");
		check(ramp_time, 16'h00fa, "ramp");
	endtask : t_write_multi

	// whole readable range, the unmapped registers 3 and 5 read zero
	task automatic t_read_all();
		#1 drive_state = 2'h2;
		drive_err = 8'h5a;
		u_mst.send({ADDR, 8'h03, 8'h00, 8'h01, 8'h00, 8'h06}, 16'h0000);
		await_reply();
		check_reply({ADDR, 8'h03, 8'h0c, 8'h00, 8'h0f, 8'h00, 8'h64, 8'h00, 8'h00, 8'h00, 8'hfa,
			8'h00, 8'h00, 8'h02, 8'h5a});
	endtask : t_read_all

	task automatic t_write_single();
		u_mst.send({ADDR, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02}, 16'h0000);
		await_reply();
		check_reply({ADDR, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02});
		check({12'h000, coast_stop, fault_reset, decel_ramp2, run_enable}, 16'h0002, "command");
	endtask : t_write_single

	task automatic t_bad_check();
		u_mst.send({ADDR, 8'h06, 8'h00, 8'h02, 8'h00, 8'h07}, 16'h0001);
		repeat (5000) @(posedge clk_sys);
		check({15'h0000, tx_oe_n}, 16'h0001, "reply to bad frame");
		check(16'(u_mst.rx_q.size()), 16'h0000, "bytes from bad frame");
		check(speed_setpoint, 16'h0064, "speed after bad frame");
	endtask : t_bad_check

	// registers 4 and 5 straddle the multi-write limit: exception, ramp untouched
	task automatic t_bad_range();
		u_mst.send({ADDR, 8'h10, 8'h00, 8'h04, 8'h00, 8'h02, 8'h04, 8'h11, 8'h11, 8'h22, 8'h22}, 16'h0000);
		await_reply();
		check_reply({ADDR, 8'h90, 8'h02});
		check(ramp_time, 16'h00fa, "ramp after range refusal");
		check(speed_setpoint, 16'h0064, "speed after range refusal");
	endtask : t_bad_range

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk_sys);
		#1 reset = 1'b0;
		t_write_multi();
		t_read_all();
		t_write_single();
		t_bad_check();
		t_bad_range();
		test_done();
	end

	// about 110k clocks of traffic expected
	initial
	begin
		repeat (130000) @(posedge clk_sys);
		n_errors++;
		test_done();
	end
endmodule : sdcs_slave_tb
